// [design/icsc_cfg.svh]
// constants for input current sense calibration block
// assumes includer is a design file of the icsc block
`ifndef ICSC_CFG_SVH
`define ICSC_CFG_SVH
`define ICSC_CMD_SENSE_CFG 8'hDA
`define ICSC_CMD_READ_IIN 8'h89
`define ICSC_PAGE_CH_A 8'h00
`define ICSC_PAGE_CH_B 8'h01
`define ICSC_DGAIN_MSB 15
`define ICSC_DGAIN_LSB 8
`define ICSC_RANGE_BIT 13
`define ICSC_OFS_MSB 12
`define ICSC_OFS_LSB 8
`define ICSC_RO_BIT 11
`define ICSC_IOUT_MSB 7
`define ICSC_IOUT_LSB 0
`define ICSC_DGAIN_NOM 8'h32
`define ICSC_DGAIN_MAX 8'h40
`define ICSC_RST_PAGE0 16'hC81E
`define ICSC_RST_PAGE1 16'h001E
`define ICSC_SAMPLE_NS 1200000
`define ICSC_CLK_NS 10
`endif

// [design/icsc_core.sv]
// input current sense calibration: paged config register and telemetry scaling
// assumes a pmbus command decoder on sys_clk presents word writes and reads, and an adc sample of the sense pins
`timescale 1ns/1ps
`include "icsc_cfg.svh"

module icsc_core import icsc_pkg::*; #(
	parameter int SAMPLE_CYCLES = `ICSC_SAMPLE_NS / `ICSC_CLK_NS,
	parameter int ADC_W = 12
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// pmbus word access, already decoded on sys_clk
	input wire logic wordWrStb,
	input wire logic wordRdStb,
	input wire logic [7:0] cmdCode,
	input wire logic [7:0] pageSel,
	input wire logic [15:0] wrData,
	output logic [15:0] rdData_ff,
	output logic rdValid_ff,
	output logic cmdInvalid_ff,
	// sense resistance code from the companion config register
	input wire logic [1:0] senseResistanceCode,
	// adc of sense_positive_pin minus sense_negative_pin, full scale = max sense voltage
	input wire logic [ADC_W-1:0] senseAdc,
	// telemetry
	output logic [15:0] inputCurrentMa_ff,
	output logic [3:0] analogSenseGainSel_ff,
	output logic [7:0] maxOutCurrentA_ff,
	output logic [7:0] maxOutCurrentB_ff
);
	// ***************
	// parameter checks
	// ***************
	if (ADC_W < 4 || ADC_W > 16) begin : gen_bad_adc_w
		$error("ADC_W out of range");
	end
	if (SAMPLE_CYCLES < 2) begin : gen_bad_sample_cycles
		$error("SAMPLE_CYCLES too small");
	end

	// ***************
	// config register copies
	// ***************
	logic [15:0] page0_ff;
	logic [15:0] page1_ff;
	logic cfgHit;
	assign cfgHit = (cmdCode == `ICSC_CMD_SENSE_CFG);

	function automatic logic [15:0] keepRo(input logic [15:0] oldV, input logic [15:0] newV);
		keepRo = newV;
		keepRo[`ICSC_RO_BIT] = oldV[`ICSC_RO_BIT];
	endfunction

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			page0_ff <= `ICSC_RST_PAGE0;
			page1_ff <= `ICSC_RST_PAGE1;
		end else if (wordWrStb && cfgHit) begin
			if (pageSel == `ICSC_PAGE_CH_A) begin
				page0_ff <= keepRo(page0_ff, wrData);
			end else if (pageSel == `ICSC_PAGE_CH_B) begin
				page1_ff <= keepRo(page1_ff, wrData);
			end
		end
	end

	// ***************
	// register readback
	// ***************
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdData_ff <= 16'h0000;
			rdValid_ff <= 1'b0;
			cmdInvalid_ff <= 1'b0;
		end else begin
			rdValid_ff <= 1'b0;
			cmdInvalid_ff <= 1'b0;
			if (wordRdStb && cfgHit && pageSel == `ICSC_PAGE_CH_A) begin
				rdData_ff <= page0_ff;
				rdValid_ff <= 1'b1;
			end else if (wordRdStb && cfgHit && pageSel == `ICSC_PAGE_CH_B) begin
				rdData_ff <= page1_ff;
				rdValid_ff <= 1'b1;
			end else if (wordRdStb && cmdCode == `ICSC_CMD_READ_IIN) begin
				rdData_ff <= inputCurrentMa_ff;
				rdValid_ff <= 1'b1;
			end else if ((wordRdStb || wordWrStb) && cfgHit) begin
				cmdInvalid_ff <= 1'b1; // any config write on any page, or a config read of a bad page
			end
		end
	end

	// ***************
	// settings out
	// ***************
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			maxOutCurrentA_ff <= 8'h00;
			maxOutCurrentB_ff <= 8'h00;
			analogSenseGainSel_ff <= 4'h0;
		end else begin
			maxOutCurrentA_ff <= page0_ff[`ICSC_IOUT_MSB:`ICSC_IOUT_LSB];
			maxOutCurrentB_ff <= page1_ff[`ICSC_IOUT_MSB:`ICSC_IOUT_LSB];
			// index 0..7 into the analog gain table, bit 2 = range
			analogSenseGainSel_ff <= {1'b0, page1_ff[`ICSC_RANGE_BIT], senseResistanceCode};
		end
	end

	// ***************
	// input current computation
	// ***************
	// full-scale current in mA: 50 A low range, 6.25 A high range
	function automatic logic [31:0] fullScaleMa(input logic rangeHi);
		fullScaleMa = rangeHi ? 32'd6250 : 32'd50000;
	endfunction

	// offset in mA, signed: code*100, codes 10h..1Fh negative
	function automatic logic signed [31:0] offsetMa(input logic [4:0] code);
		offsetMa = $signed({27'd0, code}) * 100 - (code[4] ? 32'sd3200 : 32'sd0);
	endfunction

	icsc_state_t state_ff;
	logic [31:0] cnt_ff;
	logic [31:0] acc_ff;
	logic [7:0] dGain;
	assign dGain = (page0_ff[`ICSC_DGAIN_MSB:`ICSC_DGAIN_LSB] > `ICSC_DGAIN_MAX) ?
		`ICSC_DGAIN_MAX : page0_ff[`ICSC_DGAIN_MSB:`ICSC_DGAIN_LSB];

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_ff <= 32'd0;
		end else begin
			cnt_ff <= (cnt_ff >= 32'(SAMPLE_CYCLES - 1)) ? 32'd0 : cnt_ff + 32'd1;
		end
	end

	logic signed [31:0] nxt_cur;
	always_comb begin
		nxt_cur = $signed(acc_ff / `ICSC_DGAIN_NOM) + offsetMa(page1_ff[`ICSC_OFS_MSB:`ICSC_OFS_LSB]);
		if (nxt_cur < 0) nxt_cur = 0;
		if (nxt_cur > 32'sd65535) nxt_cur = 32'sd65535;
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= ICSC_IDLE;
			acc_ff <= 32'd0;
			inputCurrentMa_ff <= 16'h0000;
		end else begin
			case (state_ff)
				ICSC_IDLE: begin
					if (cnt_ff == 32'd0) begin
						// sample times full scale over adc span
						acc_ff <= (32'(senseAdc) * fullScaleMa(page1_ff[`ICSC_RANGE_BIT])) >> ADC_W;
						state_ff <= ICSC_MUL;
					end
				end
				ICSC_MUL: begin
					acc_ff <= acc_ff * 32'(dGain);
					state_ff <= ICSC_OUT;
				end
				ICSC_OUT: begin
					inputCurrentMa_ff <= nxt_cur[15:0];
					state_ff <= ICSC_IDLE;
				end
				default: begin
					state_ff <= ICSC_IDLE;
				end
			endcase
		end
	end

	// ***************
	// checks
	// ***************
	AST_RO_BIT_KEPT: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(wordWrStb && cfgHit && pageSel == `ICSC_PAGE_CH_A) |=> page0_ff[`ICSC_RO_BIT] == $past(page0_ff[`ICSC_RO_BIT]))
		else $error("read-only bit changed");
	AST_PAGE0_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(wordWrStb && cfgHit && pageSel == `ICSC_PAGE_CH_A) |=> page0_ff[15:12] == $past(wrData[15:12]))
		else $error("page 0 write lost");
	AST_PAGE1_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(wordWrStb && cfgHit && pageSel == `ICSC_PAGE_CH_B) |=> page1_ff[13:12] == $past(wrData[13:12]) && $stable(page0_ff))
		else $error("page 1 write wrong");
	AST_IOUT_B: assert property (@(posedge sys_clk) disable iff (!rst_b)
		1'b1 |=> maxOutCurrentB_ff == $past(page1_ff[7:0]))
		else $error("max output current b wrong");
	AST_RANGE_SEL: assert property (@(posedge sys_clk) disable iff (!rst_b)
		1'b1 |=> analogSenseGainSel_ff[2] == $past(page1_ff[`ICSC_RANGE_BIT]))
		else $error("range bit not applied");
	AST_DGAIN_CAP: assert property (@(posedge sys_clk) disable iff (!rst_b) dGain <= 8'd64)
		else $error("digital gain above cap");
	AST_PIPE: assert property (@(posedge sys_clk) disable iff (!rst_b)
		state_ff == ICSC_MUL |=> state_ff == ICSC_OUT ##1 state_ff == ICSC_IDLE)
		else $error("pipeline stalled");
	AST_IIN_READ: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(wordRdStb && cmdCode == `ICSC_CMD_READ_IIN) |=> rdValid_ff && rdData_ff == $past(inputCurrentMa_ff))
		else $error("input current readback wrong");
	COV_WR_P0: cover property (@(posedge sys_clk) wordWrStb && cfgHit && pageSel == `ICSC_PAGE_CH_A);
	COV_WR_P1: cover property (@(posedge sys_clk) wordWrStb && cfgHit && pageSel == `ICSC_PAGE_CH_B);
	AST_BAD_PAGE: assert property (@(posedge sys_clk) disable iff (!rst_b)
		((wordWrStb || wordRdStb) && cfgHit && pageSel != `ICSC_PAGE_CH_A && pageSel != `ICSC_PAGE_CH_B) |=> cmdInvalid_ff && $stable(page0_ff) && $stable(page1_ff))
		else $error("bad page access not refused");
	AST_IOUT_A: assert property (@(posedge sys_clk) disable iff (!rst_b)
		1'b1 |=> maxOutCurrentA_ff == $past(page0_ff[7:0]))
		else $error("max output current a wrong");
	COV_IIN: cover property (@(posedge sys_clk) state_ff == ICSC_OUT && nxt_cur > 0);
	COV_IIN_READ: cover property (@(posedge sys_clk) wordRdStb && cmdCode == `ICSC_CMD_READ_IIN);
	COV_RANGE_HI: cover property (@(posedge sys_clk) state_ff == ICSC_OUT && page1_ff[`ICSC_RANGE_BIT]);
endmodule

// [design/icsc_pkg.sv]
// types for input current sense calibration block
// assumes nothing of its surroundings
package icsc_pkg;
	typedef enum logic [1:0] {
		ICSC_IDLE = 2'b00,
		ICSC_MUL = 2'b01,
		ICSC_DIV = 2'b10,
		ICSC_OUT = 2'b11
	} icsc_state_t;
endpackage

// [verif/icsc_host.sv]
// pmbus host model: word writes and word reads to the sense block
// assumes the bench calls its tasks; drives at the falling edge
`timescale 1ns/1ps
module icsc_host (
	// clock
	input wire logic sys_clk,
	// request
	output logic wordWrStb,
	output logic wordRdStb,
	output logic [7:0] cmdCode,
	output logic [7:0] pageSel,
	output logic [15:0] wrData,
	// answer
	input wire logic [15:0] rdData_ff,
	input wire logic rdValid_ff
);
	initial begin
		wordWrStb = 1'b0;
		wordRdStb = 1'b0;
		cmdCode = 8'h00;
		pageSel = 8'h00;
		wrData = 16'h0000;
	end
	// word write, page picks channel copy
	task automatic wr(input logic [7:0] page, input logic [15:0] data);
		@(negedge sys_clk);
		cmdCode = 8'hDA;
		pageSel = page;
		wrData = data;
		wordWrStb = 1'b1;
		@(negedge sys_clk);
		wordWrStb = 1'b0;
		// released lines show junk
		wrData = ~wrData;
	endtask
	// word read, answer sampled in the cycle after the request
	task automatic rd(input logic [7:0] page, output logic [15:0] data, output logic ok);
		@(negedge sys_clk);
		cmdCode = 8'hDA;
		pageSel = page;
		wordRdStb = 1'b1;
		@(negedge sys_clk);
		wordRdStb = 1'b0;
		data = rdData_ff;
		ok = rdValid_ff;
	endtask
	// word read of the combined input current, page does not matter
	task automatic rdIin(output logic [15:0] data, output logic ok);
		@(negedge sys_clk);
		cmdCode = 8'h89;
		wordRdStb = 1'b1;
		@(negedge sys_clk);
		wordRdStb = 1'b0;
		data = rdData_ff;
		ok = rdValid_ff;
	endtask
endmodule

// [verif/test_icsc_core.sv]
// self-checking bench for the input current sense calibration core
// assumes the design files and the host model are compiled first
`timescale 1ns/1ps
module test_icsc_core;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic wordWrStb, wordRdStb, rdValid_ff, cmdInvalid_ff, ok;
	logic [7:0] cmdCode, pageSel, maxA, maxB;
	logic [15:0] wrData, rdData_ff, curMa, rd;
	logic [1:0] senseResistanceCode = 2'h0;
	logic [11:0] senseAdc = 12'h800;
	logic [3:0] gainSel;
	int n_mismatch = 0;
	int n_compared = 0;
	int cyc = 0;
	always #5 sys_clk = ~sys_clk;
	icsc_core #(.SAMPLE_CYCLES(8), .ADC_W(12)) dut (.sys_clk(sys_clk), .rst_b(rst_b), .wordWrStb(wordWrStb),
		.wordRdStb(wordRdStb), .cmdCode(cmdCode), .pageSel(pageSel), .wrData(wrData), .rdData_ff(rdData_ff),
		.rdValid_ff(rdValid_ff), .cmdInvalid_ff(cmdInvalid_ff), .senseResistanceCode(senseResistanceCode),
		.senseAdc(senseAdc), .inputCurrentMa_ff(curMa), .analogSenseGainSel_ff(gainSel),
		.maxOutCurrentA_ff(maxA), .maxOutCurrentB_ff(maxB));
	icsc_host host (.sys_clk(sys_clk), .wordWrStb(wordWrStb), .wordRdStb(wordRdStb), .cmdCode(cmdCode),
		.pageSel(pageSel), .wrData(wrData), .rdData_ff(rdData_ff), .rdValid_ff(rdValid_ff));
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// program gain, range and offset, let samples pass, check current
	task automatic cal(input logic [7:0] dg, input logic rng, input logic [4:0] ofs, input logic [15:0] ma);
		host.wr(8'h00, {dg, 8'h1E});
		host.wr(8'h01, {2'b00, rng, ofs, 8'h14});
		repeat (24) @(negedge sys_clk);
		cmp(curMa, ma);
	endtask
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_mismatch++;
			end_sim();
		end
	end
	// ****************************
	// main sequence
	// ****************************
	initial begin
		repeat (4) @(negedge sys_clk);
		rst_b = 1'b1;
		host.rd(8'h00, rd, ok);
		cmp(rd, 16'hC81E);
		cmp({15'h0000, ok}, 16'h0001);
		host.rd(8'h01, rd, ok);
		cmp(rd, 16'h001E);
		host.wr(8'h02, 16'h0000);
		cmp({15'h0000, cmdInvalid_ff}, 16'h0001);
		host.rd(8'h00, rd, ok);
		cmp(rd, 16'hC81E);
		for (int i = 0; i < 8; i++) begin
			senseResistanceCode = i[1:0];
			host.wr(8'h01, {2'b00, i[2], 5'h00, 8'h14});
			repeat (2) @(negedge sys_clk);
			cmp({12'h000, gainSel}, {13'h0000, i[2:0]});
		end
		cmp({maxA, maxB}, 16'h1E14);
		// bit 11 keeps its reset value on both pages
		host.wr(8'h00, 16'h0000);
		host.rd(8'h00, rd, ok);
		cmp(rd, 16'h0800);
		host.wr(8'h01, 16'h0814);
		host.rd(8'h01, rd, ok);
		cmp(rd, 16'h0014);
		// digital gain bit 3 stays 1 and offset bit 3 stays 0 (read-only bit 11)
		cal(8'h3A, 1'b0, 5'h00, 16'h7148);
		host.rdIin(rd, ok);
		cmp(rd, 16'h7148);
		cmp({15'h0000, ok}, 16'h0001);
		cal(8'h19, 1'b0, 5'h00, 16'h30D4);
		cal(8'h19, 1'b0, 5'h10, 16'h2A94);
		cal(8'h19, 1'b0, 5'h07, 16'h3390);
		cal(8'h40, 1'b0, 5'h00, 16'h7D00);
		cal(8'h3A, 1'b1, 5'h00, 16'h0E29);
		end_sim();
	end
endmodule
